// ---- verilog/csi_contour.sv ----
`timescale 1ns/1ns
module csi_contour
    import csi_pkg::*;
#(
    parameter int unsigned SAMPLE_CYC = SAMPLE_CYCLES
)
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               srst,
    // Contour axis select command
    input  wire logic               axis_sel_wr,
    input  wire logic [NAX-1:0]     axis_sel,
    // Segment interval setting command
    input  wire logic               ivl_wr,
    input  wire logic [3:0]         ivl_val,
    // Contour increment entry command
    input  wire logic               entry_wr,
    input  wire csi_incs_t          entry_inc,
    input  wire logic               entry_has_ivl,
    input  wire logic [3:0]         entry_ivl,
    // Status
    output logic                    contour_active_q,
    output logic [NAX-1:0]          axis_mask_q,
    output logic                    waiting_q,
    output logic [8:0]              buffer_space_q,
    output logic                    entry_err_q,
    // Commanded points
    output logic                    point_valid_q,
    output logic [NAX-1:0][POS_W-1:0] cmd_pos_q
);

    function automatic logic csi_incs_zero(input csi_incs_t incs);
        logic z;
        z = 1'b1;
        for (int a = 0; a < NAX; a++)
            z = z && (incs[a] == '0);
        return z;
    endfunction : csi_incs_zero

    function automatic logic csi_incs_ok(input csi_incs_t incs);
        logic ok;
        ok = 1'b1;
        for (int a = 0; a < NAX; a++)
            ok = ok && ($signed(incs[a]) <= $signed(INC_LIMIT))
                    && ($signed(incs[a]) >= -$signed(INC_LIMIT));
        return ok;
    endfunction : csi_incs_ok

    function automatic logic [8:0] csi_next_ptr(input logic [8:0] p);
        return (p == BUF_DEPTH - 9'h001) ? 9'h000 : p + 9'h001;
    endfunction : csi_next_ptr

    csi_seg_if seg ();

    csi_state_t  state_q;
    csi_state_t  state_d;
    logic [15:0] div_q;
    logic        tick_q;
    logic [3:0]  cur_ivl_q;
    logic        closed_q;
    logic [8:0]  wr_ptr_q;
    logic [8:0]  rd_ptr_q;
    logic [8:0]  cnt_q;
    logic [8:0]  cnt_d;
    logic [8:0]  smp_left_q;
    csi_incs_t   inc_mem [BUF_DEPTH];
    logic [3:0]  ivl_mem [BUF_DEPTH];

    logic [3:0]  res_ivl;
    logic        in_zero;
    logic        entry_ok;
    logic        push;
    logic        pop;
    logic        sel_ok;
    logic        ivl_ok;
    logic        head_marker;
    logic        seg_end;

    // Sample period divider
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end
        else if (div_q == 16'(SAMPLE_CYC - 1))
        begin
            div_q  <= '0;
            tick_q <= 1'b1;
        end
        else
        begin
            div_q  <= div_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

    // Command decode
    assign res_ivl  = entry_has_ivl ? entry_ivl : cur_ivl_q;
    assign in_zero  = csi_incs_zero(entry_inc);
    assign entry_ok = (state_q != CSI_IDLE) && !closed_q && (cnt_q != BUF_DEPTH)
                      && csi_incs_ok(entry_inc)
                      && (res_ivl <= IVL_MAX)
                      && ((res_ivl != 4'h0) || in_zero);
    assign push     = entry_wr && entry_ok;
    assign sel_ok   = axis_sel_wr && (state_q == CSI_IDLE) && (axis_sel != '0);
    assign ivl_ok   = ivl_wr && (ivl_val <= IVL_MAX);

    // Head of queue; only the end marker carries interval zero
    assign head_marker = (ivl_mem[rd_ptr_q] == 4'h0);
    assign seg_end     = (state_q == CSI_RUN) && tick_q && (smp_left_q == 9'h001);
    assign pop         = seg_end || ((state_q == CSI_WAIT) && (cnt_q != '0) && head_marker);

    assign seg.load  = (state_q == CSI_WAIT) && (cnt_q != '0) && !head_marker;
    assign seg.tick  = (state_q == CSI_RUN) && tick_q;
    assign seg.inc   = inc_mem[rd_ptr_q];
    assign seg.shift = ivl_mem[rd_ptr_q];

    csi_interp u_interp (
        .clk  (clk),
        .srst (srst),
        .seg  (seg)
    );

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            CSI_IDLE:
                if (sel_ok)
                    state_d = CSI_WAIT;
            CSI_WAIT:
                if (cnt_q != '0)
                    state_d = head_marker ? CSI_IDLE : CSI_RUN;
            CSI_RUN:
                if (seg_end)
                    state_d = CSI_WAIT;
            default:
                state_d = CSI_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            state_q <= CSI_IDLE;
        else
            state_q <= state_d;
    end

    // Interval memory of the most recent setting
    always_ff @(posedge clk)
    begin
        if (srst)
            cur_ivl_q <= IVL_RESET;
        else if (push && entry_has_ivl)
            cur_ivl_q <= entry_ivl;
        else if (ivl_ok)
            cur_ivl_q <= ivl_val;
    end

    // After the end marker is queued, further entries are refused
    always_ff @(posedge clk)
    begin
        if (srst || sel_ok)
            closed_q <= 1'b0;
        else if (push && (res_ivl == 4'h0))
            closed_q <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            axis_mask_q <= '0;
        else if (sel_ok)
            axis_mask_q <= axis_sel;
    end

    // Contour buffer, strictly first in first out
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            inc_mem[wr_ptr_q] <= entry_inc;
            ivl_mem[wr_ptr_q] <= res_ivl;
        end
    end

    assign cnt_d = cnt_q + {8'h00, push} - {8'h00, pop};

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= csi_next_ptr(wr_ptr_q);
            if (pop)
                rd_ptr_q <= csi_next_ptr(rd_ptr_q);
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            smp_left_q <= '0;
        else if (seg.load)
            smp_left_q <= 9'h001 << seg.shift;
        else if (seg.tick)
            smp_left_q <= smp_left_q - 9'h001;
    end

    // Commanded points; only contour axes move, others are left alone
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            point_valid_q <= 1'b0;
            cmd_pos_q     <= '0;
        end
        else
        begin
            point_valid_q <= seg.tick;
            for (int a = 0; a < NAX; a++)
            begin
                if (seg.tick && axis_mask_q[a])
                    cmd_pos_q[a] <= cmd_pos_q[a] + POS_W'($signed(seg.step[a]));
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            contour_active_q <= 1'b0;
            waiting_q        <= 1'b0;
            buffer_space_q   <= BUF_DEPTH;
            entry_err_q      <= 1'b0;
        end
        else
        begin
            contour_active_q <= (state_d != CSI_IDLE);
            waiting_q        <= (state_d == CSI_WAIT) && (cnt_d == '0);
            buffer_space_q   <= BUF_DEPTH - cnt_d;
            entry_err_q      <= (entry_wr && !entry_ok) || (axis_sel_wr && !sel_ok)
                                || (ivl_wr && !ivl_ok);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence s_seg_last;
        (state_q == CSI_RUN) && tick_q && (smp_left_q == 9'h001);
    endsequence

    sequence s_waiting_empty;
        (state_q == CSI_WAIT) && (cnt_q == '0);
    endsequence

    a_axis_select: assert property (sel_ok |=> contour_active_q && (axis_mask_q == $past(axis_sel)))
        else $error("axis selection not taken");
    a_other_axes: assert property (!axis_mask_q[1] |=> $stable(cmd_pos_q[1]))
        else $error("non-contour axis moved");
    a_seg_length: assert property (seg.load |=> smp_left_q == (9'h001 << $past(seg.shift)))
        else $error("segment length not two to the interval");
    a_point_each: assert property ((state_q == CSI_RUN) && tick_q |=> point_valid_q)
        else $error("no point on a running sample");
    a_ivl_adopt: assert property (push && entry_has_ivl |=> cur_ivl_q == $past(entry_ivl))
        else $error("entry interval not adopted");
    a_ivl_reuse: assert property (push && !entry_has_ivl
                                  |=> ivl_mem[$past(wr_ptr_q)] == $past(cur_ivl_q))
        else $error("previous interval not reused");
    a_range_err: assert property (entry_wr && !csi_incs_ok(entry_inc)
                                  |=> entry_err_q && (wr_ptr_q == $past(wr_ptr_q)))
        else $error("out of range increment accepted");
    a_marker_exit: assert property ((state_q == CSI_WAIT) && (cnt_q != '0) && head_marker
                                    |=> !contour_active_q ##1 !point_valid_q)
        else $error("end marker did not stop consumption");
    a_space_empty: assert property ((cnt_q == '0) |-> buffer_space_q == 9'h1ff)
        else $error("empty buffer not reported as 511");
    a_zero_exit: assert property (ivl_ok && (ivl_val == 4'h0) && !entry_wr ##1 !ivl_wr && !entry_wr
                                  ##1 push && !entry_has_ivl |=> closed_q)
        else $error("zero interval then zero data not closing");
    a_wait_still: assert property (s_waiting_empty |=> !point_valid_q)
        else $error("point produced while waiting");
    a_bad_reject: assert property (entry_wr && (state_q == CSI_IDLE) |=> entry_err_q && (cnt_q == '0))
        else $error("entry outside contour mode not rejected");
    a_free_entry: assert property (s_seg_last ##0 !push |=> cnt_q == $past(cnt_q) - 9'h001)
        else $error("finished segment did not free an entry");

endmodule : csi_contour

// ---- verilog/csi_pkg.sv ----
package csi_pkg;

    localparam int unsigned NAX              = 8;
    localparam int unsigned INC_W            = 16;
    localparam int unsigned POS_W            = 32;
    localparam int unsigned ACC_W            = 24;
    localparam logic [8:0]  BUF_DEPTH        = 9'h1ff;
    localparam logic [15:0] INC_LIMIT        = 16'h7d00;
    localparam logic [3:0]  IVL_MAX          = 4'h8;
    localparam logic [3:0]  IVL_RESET        = 4'h1;
    localparam int unsigned CLK_PERIOD_NS    = 100;
    localparam int unsigned SAMPLE_PERIOD_NS = 32'h000f4240;
    localparam int unsigned SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

    typedef logic [NAX-1:0][INC_W-1:0] csi_incs_t;

    typedef enum logic [1:0] {
        CSI_IDLE = 2'b00,
        CSI_WAIT = 2'b01,
        CSI_RUN  = 2'b10
    } csi_state_t;

endpackage : csi_pkg

// ---- verilog/csi_seg_if.sv ----
`timescale 1ns/1ns
interface csi_seg_if;
    import csi_pkg::*;

    logic       load;
    logic       tick;
    csi_incs_t  inc;
    logic [3:0] shift;
    csi_incs_t  step;

    modport seq    (output load, output tick, output inc, output shift, input step);
    modport interp (input load, input tick, input inc, input shift, output step);
endinterface : csi_seg_if

// ---- verilog/csi_interp.sv ----
`timescale 1ns/1ns
module csi_interp
    import csi_pkg::*;
(
    // Clock and reset
    input wire logic   clk,
    input wire logic   srst,
    // Segment link
    csi_seg_if.interp  seg
);

    function automatic logic signed [ACC_W-1:0] csi_sum(input logic signed [ACC_W-1:0] acc,
                                                         input logic [INC_W-1:0]        inc);
        return acc + ACC_W'($signed(inc));
    endfunction : csi_sum

    logic signed [ACC_W-1:0] acc_q [NAX];
    logic [8:0]              tick_cnt_q;
    logic [3:0]              shift_q;

    // Step is the whole part of the residual; the fraction stays for later samples
    always_comb
    begin
        for (int a = 0; a < NAX; a++)
        begin
            seg.step[a] = INC_W'(csi_sum(acc_q[a], seg.inc[a]) >>> seg.shift);
        end
    end

    always_ff @(posedge clk)
    begin
        for (int a = 0; a < NAX; a++)
        begin
            if (srst || seg.load)
                acc_q[a] <= '0;
            else if (seg.tick)
                acc_q[a] <= csi_sum(acc_q[a], seg.inc[a])
                            - (ACC_W'($signed(seg.step[a])) <<< seg.shift);
        end
    end

    // Helper: samples taken since the segment was loaded
    always_ff @(posedge clk)
    begin
        if (srst || seg.load)
            tick_cnt_q <= '0;
        else if (seg.tick)
            tick_cnt_q <= tick_cnt_q + 9'h001;
    end

    // Helper: interval of the loaded segment, kept after the queue head moves on
    always_ff @(posedge clk)
    begin
        if (srst)
            shift_q <= '0;
        else if (seg.load)
            shift_q <= seg.shift;
    end

    function automatic logic csi_acc_clear();
        logic z;
        z = 1'b1;
        for (int a = 0; a < NAX; a++)
            z = z && (acc_q[a] == '0);
        return z;
    endfunction : csi_acc_clear

    a_sum_exact: assert property (@(posedge clk) disable iff (srst)
        (tick_cnt_q == (9'h001 << shift_q)) |-> csi_acc_clear())
        else $error("segment residual not zero at segment end");

endmodule : csi_interp

// ---- sim/csi_host_model.sv ----
`timescale 1ns/1ns
module csi_host_model
    import csi_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Commands to the block
    output logic            axis_sel_wr,
    output logic [NAX-1:0]  axis_sel,
    output logic            ivl_wr,
    output logic [3:0]      ivl_val,
    output logic            entry_wr,
    output csi_incs_t       entry_inc,
    output logic            entry_has_ivl,
    output logic [3:0]      entry_ivl
);
    initial
    begin
        {axis_sel_wr, ivl_wr, entry_wr, entry_has_ivl} = 4'h0;
        axis_sel = 8'h00;
        ivl_val = 4'h1;
        entry_inc = '0;
        entry_ivl = 4'h1;
    end

    // Data lines show junk once the strobe is gone
    task automatic select_axes(input logic [NAX-1:0] m);
        @(posedge clk);
        #1 axis_sel_wr = 1'b1;
        axis_sel = m;
        @(posedge clk);
        #1 axis_sel_wr = 1'b0;
        axis_sel = ~m;
    endtask : select_axes

    task automatic set_interval(input logic [3:0] v);
        @(posedge clk);
        #1 ivl_wr = 1'b1;
        ivl_val = v;
        @(posedge clk);
        #1 ivl_wr = 1'b0;
        ivl_val = ~v;
    endtask : set_interval

    task automatic send_entry(input logic [15:0] a0, input logic [15:0] a1, input logic h, input logic [3:0] v);
        @(posedge clk);
        #1 entry_wr = 1'b1;
        entry_inc = '0;
        entry_inc[0] = a0;
        entry_inc[1] = a1;
        entry_has_ivl = h;
        entry_ivl = v;
        @(posedge clk);
        #1 entry_wr = 1'b0;
        entry_inc = ~entry_inc;
        entry_has_ivl = ~h;
        entry_ivl = ~v;
    endtask : send_entry
endmodule : csi_host_model

// ---- sim/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
    import csi_pkg::*;
    localparam int unsigned SCYC = 8;
    logic                      clk = 1'b0;
    logic                      srst = 1'b1;
    logic                      axis_sel_wr, ivl_wr, entry_wr, entry_has_ivl;
    logic [NAX-1:0]            axis_sel, axis_mask_q;
    logic [3:0]                ivl_val, entry_ivl;
    csi_incs_t                 entry_inc;
    logic                      contour_active_q, waiting_q, entry_err_q, point_valid_q;
    logic [8:0]                buffer_space_q;
    logic [NAX-1:0][POS_W-1:0] cmd_pos_q;
    int                        failures = 0;
    int                        checked = 0;
    int                        points = 0;
    int                        errs = 0;
    int                        p0, e0;

    always #50 clk = ~clk;

    csi_host_model i_host (.clk(clk), .axis_sel_wr(axis_sel_wr), .axis_sel(axis_sel), .ivl_wr(ivl_wr),
        .ivl_val(ivl_val), .entry_wr(entry_wr), .entry_inc(entry_inc), .entry_has_ivl(entry_has_ivl),
        .entry_ivl(entry_ivl));

    csi_contour #(.SAMPLE_CYC(SCYC)) i_dut (.clk(clk), .srst(srst), .axis_sel_wr(axis_sel_wr),
        .axis_sel(axis_sel), .ivl_wr(ivl_wr), .ivl_val(ivl_val), .entry_wr(entry_wr), .entry_inc(entry_inc),
        .entry_has_ivl(entry_has_ivl), .entry_ivl(entry_ivl), .contour_active_q(contour_active_q),
        .axis_mask_q(axis_mask_q), .waiting_q(waiting_q), .buffer_space_q(buffer_space_q),
        .entry_err_q(entry_err_q), .point_valid_q(point_valid_q), .cmd_pos_q(cmd_pos_q));

    // Pulse counters for points and rejections
    always @(posedge clk)
    begin
        if (point_valid_q === 1'b1)
            points++;
        if (entry_err_q === 1'b1)
            errs++;
    end

    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp

    task automatic finish_test;
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : settle

    // Kind 0: buffer drained and waiting; kind 1: mode left; kind 2: one more point
    task automatic wait_for(input int kind);
        int k;
        int p;
        k = 0;
        p = points;
        while (k < 2000 && !((kind == 0 && buffer_space_q === 9'h1ff && waiting_q === 1'b1) ||
               (kind == 1 && contour_active_q === 1'b0) || (kind == 2 && points > p)))
        begin
            settle(1);
            k++;
        end
        // Let the last point pulse be counted before anyone reads the tally
        settle(1);
        cmp("wait bound", 32'h0, (k >= 2000) ? 32'h1 : 32'h0);
    endtask : wait_for

    task automatic test_reset;
        cmp("active", 32'h0, 32'(contour_active_q));
        cmp("space", 32'h1ff, 32'(buffer_space_q));
        cmp("pos0", 32'h0, cmd_pos_q[0]);
        e0 = errs;
        i_host.send_entry(16'h0005, 16'h0000, 1'b1, 4'h2);
        i_host.select_axes(8'h00);
        settle(3);
        cmp("idle errs", 32'(e0 + 2), 32'(errs));
        cmp("idle active", 32'h0, 32'(contour_active_q));
    endtask : test_reset

    task automatic test_segments;
        i_host.select_axes(8'h01);
        settle(2);
        cmp("mask", 32'h1, 32'(axis_mask_q));
        cmp("waiting", 32'h1, 32'(waiting_q));
        p0 = points;
        i_host.send_entry(16'h0030, 16'h0064, 1'b1, 4'h2);
        settle(2);
        cmp("space one", 32'h1fe, 32'(buffer_space_q));
        wait_for(2);
        settle(1);
        cmp("first point", 32'hc, cmd_pos_q[0]);
        wait_for(0);
        cmp("points ivl2", 32'(p0 + 4), 32'(points));
        cmp("pos0 seg1", 32'h30, cmd_pos_q[0]);
        cmp("pos1 free", 32'h0, cmd_pos_q[1]);
        p0 = points;
        settle(5 * SCYC);
        cmp("no motion", 32'(p0), 32'(points));
        i_host.send_entry(16'h0007, 16'h0000, 1'b0, 4'h0);
        settle(2);
        wait_for(0);
        cmp("points reuse", 32'(p0 + 4), 32'(points));
        cmp("pos0 seg2", 32'h37, cmd_pos_q[0]);
        i_host.send_entry(16'hfffd, 16'h0000, 1'b1, 4'h1);
        i_host.send_entry(16'h0005, 16'h0000, 1'b0, 4'h0);
        settle(1);
        wait_for(0);
        cmp("points two", 32'(p0 + 8), 32'(points));
        cmp("pos0 seg4", 32'h39, cmd_pos_q[0]);
    endtask : test_segments

    task automatic test_bad_data;
        e0 = errs;
        i_host.send_entry(16'h7d01, 16'h0000, 1'b1, 4'h1);
        i_host.send_entry(16'h0005, 16'h0000, 1'b1, 4'h0);
        i_host.set_interval(4'h9);
        settle(3);
        cmp("bad errs", 32'(e0 + 3), 32'(errs));
        cmp("bad space", 32'h1ff, 32'(buffer_space_q));
        i_host.send_entry(16'h8300, 16'h0000, 1'b1, 4'h1);
        settle(2);
        wait_for(0);
        cmp("pos0 min", 32'hffff8339, cmd_pos_q[0]);
    endtask : test_bad_data

    task automatic test_end;
        i_host.send_entry(16'h0000, 16'h0000, 1'b1, 4'h0);
        wait_for(1);
        cmp("end active", 32'h0, 32'(contour_active_q));
        e0 = errs;
        i_host.send_entry(16'h0001, 16'h0000, 1'b1, 4'h1);
        settle(3);
        cmp("end errs", 32'(e0 + 1), 32'(errs));
        i_host.select_axes(8'h81);
        settle(2);
        cmp("mask two", 32'h81, 32'(axis_mask_q));
        i_host.set_interval(4'h0);
        i_host.send_entry(16'h0000, 16'h0000, 1'b0, 4'h0);
        wait_for(1);
        cmp("exit active", 32'h0, 32'(contour_active_q));
    endtask : test_end

    initial
    begin
        #(20000 * 100);
        failures++;
        finish_test();
    end

    initial
    begin
        repeat (16) @(posedge clk);
        #1 srst = 1'b0;
        settle(1);
        test_reset();
        test_segments();
        test_bad_data();
        test_end();
        finish_test();
    end
endmodule : tb_top
